// ### core/rpr_pkg.sv
// constants, command codes and carrier types for the pressure period readout
// assumes a single 125 MHz clock and an APB3 register bus with 8-bit byte addresses
package rpr_pkg;

  // clock and time base
  localparam int unsigned REF_CLK_HZ     = 125_000_000;
  localparam int unsigned NS_PER_S       = 1_000_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned NS_PER_US      = 1000;
  localparam int unsigned CLK_PERIOD_NS  = NS_PER_S / REF_CLK_HZ;
  localparam int unsigned CYC_PER_MS_DEF = REF_CLK_HZ / MS_PER_S;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_PINT = 8'h08;
  localparam logic [7:0] ADDR_TINT = 8'h0c;
  localparam logic [7:0] ADDR_HOLD = 8'h10;
  localparam logic [7:0] ADDR_TARE = 8'h14;
  localparam logic [7:0] ADDR_TEMP = 8'h18;
  localparam logic [7:0] ADDR_COEF = 8'h40;

  // control fields
  localparam int CTRL_CMD_LSB  = 0;
  localparam int CTRL_KIND_LSB = 4;
  localparam int CTRL_TARE_BIT = 8;

  // coefficient table entries, one word each from ADDR_COEF upward
  localparam int CI_U0   = 0;
  localparam int CI_Y1   = 1;
  localparam int CI_Y2   = 2;
  localparam int CI_Y3   = 3;
  localparam int CI_C1   = 4;
  localparam int CI_C2   = 5;
  localparam int CI_C3   = 6;
  localparam int CI_D1   = 7;
  localparam int CI_D2   = 8;
  localparam int CI_T1   = 9;
  localparam int CI_T2   = 10;
  localparam int CI_T3   = 11;
  localparam int CI_T4   = 12;
  localparam int CI_T5   = 13;
  localparam int CI_SPAN = 14;
  localparam int CI_ZERO = 15;
  localparam int CI_UNIT = 16;
  localparam int NCOEF   = 17;

  // reset values, coefficients are signed Q16.16, gate times are in milliseconds
  localparam logic [31:0] FX_ONE   = 32'h0001_0000;
  localparam logic [15:0] PINT_RST = 16'h03e8;
  localparam logic [15:0] TINT_RST = 16'h03e8;
  localparam logic [NCOEF-1:0][31:0] COEF_RST =
    '{CI_SPAN: FX_ONE, CI_UNIT: FX_ONE, default: 32'h0};

  // sequencing counts
  localparam logic [4:0] HS_LAST   = 5'h0f;
  localparam logic [6:0] DIV_STEPS = 7'h40;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_SINGLE, CMD_CONT, CMD_FAST, CMD_TRIG, CMD_READ, CMD_STOP, CMD_TARE
  } rpr_cmd_t;

  typedef enum logic [1:0] {KIND_PRES, KIND_TEMP, KIND_PPER, KIND_TPER} rpr_kind_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rpr_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rpr_apb_rsp_t;

  typedef struct packed {
    logic        valid;
    rpr_kind_t   kind;
    logic        tare;
    logic [31:0] data;
  } rpr_result_t;

endpackage

// ### core/rpr_readout.sv
// period counter, compensation arithmetic and sampling sequencer with APB registers
// assumes transducer inputs synchronous to core_clk and a host that drains result words
module rpr_readout #(
  parameter int unsigned CYC_PER_MS = rpr_pkg::CYC_PER_MS_DEF
) (
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire rpr_pkg::rpr_apb_req_t apbReq,
  output rpr_pkg::rpr_apb_rsp_t      apbRsp,
  input  wire logic                  presSig,
  input  wire logic                  tempSig,
  output rpr_pkg::rpr_result_t       result
);
  import rpr_pkg::*;

  typedef enum {IDLE, GATE, DIV, CALC_T, CALC_P, CALC_F, EMIT} rpr_fsm_t;

  typedef struct packed {
    rpr_fsm_t                fsm;
    rpr_apb_rsp_t            rsp;
    rpr_result_t             res;
    logic [15:0]             pInt, tInt;
    logic [NCOEF-1:0][31:0]  coef;
    logic [31:0]             tare, hold, tPer, pPer, u, xv;
    logic [31:0]             acc, cC, dD, tempC, lastPres;
    logic                    tareEn, stopReq, holdValid, holdTare;
    logic                    gSel, armed, dRatio, tempOk;
    rpr_cmd_t                mode;
    rpr_kind_t               kind, holdKind;
    logic [1:0]              sigPrev;
    logic [33:0]             gateCnt, refCnt, lastRef, edges;
    logic [63:0]             dNum;
    logic [47:0]             dRem, dDen;
    logic [6:0]              dCnt;
    logic [4:0]              hsCnt;
    logic [3:0]              step;
  } rpr_regs_t;

  rpr_regs_t   st;
  rpr_regs_t   stNext;
  logic        access, wrEn, hit, coefHit, rise, launch, startGate, gateSel, busy;
  rpr_cmd_t    cmd;
  logic [4:0]  coefIdx;
  logic [31:0] rdata;
  logic [48:0] remTry;
  logic [15:0] gateMs;
  logic [33:0] gateLen;
  // signed Q16.16 multiply
  function automatic logic [31:0] fxMul(input logic [31:0] a, input logic [31:0] b);
    logic signed [63:0] p;
    p = $signed(a) * $signed(b);
    return p[47:16];
  endfunction
  // gate length in reference cycles, zero milliseconds acts as one
  assign gateMs  = st.gSel ? st.pInt : st.tInt;
  assign gateLen = 34'((gateMs == 16'h0) ? 16'h1 : gateMs) * 34'(CYC_PER_MS);
  // outputs come straight from the state register
  assign apbRsp = st.rsp;
  assign result = st.res;

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    stNext    = st;
    launch    = 1'b0;
    startGate = 1'b0;
    gateSel   = 1'b0;
    busy      = (st.fsm != IDLE);
    cmd       = rpr_cmd_t'(apbReq.pwdata[CTRL_CMD_LSB +: 3]);
    rise      = st.gSel ? (presSig & ~st.sigPrev[1]) : (tempSig & ~st.sigPrev[0]);
    remTry    = {st.dRem, st.dNum[63]};
    access    = apbReq.psel & apbReq.penable;
    coefIdx   = 5'((apbReq.paddr - ADDR_COEF) >> 2);
    coefHit   = (apbReq.paddr >= ADDR_COEF) && (apbReq.paddr[1:0] == 2'b00)
                && ((apbReq.paddr - ADDR_COEF) < 8'(4 * NCOEF)); // full offset, no alias
    hit       = 1'b1;
    rdata     = 32'h0;
    stNext.res.valid = 1'b0;
    stNext.sigPrev   = {presSig, tempSig};

    // read decode
    case (apbReq.paddr)
      ADDR_CTRL: rdata = {23'h0, st.tareEn, 2'h0, st.kind, 1'b0, st.mode};
      ADDR_STAT: rdata = {27'h0, st.tareEn, st.stopReq, st.holdValid, st.tempOk, busy};
      ADDR_PINT: rdata = {16'h0, st.pInt};
      ADDR_TINT: rdata = {16'h0, st.tInt};
      ADDR_HOLD: rdata = st.hold;
      ADDR_TARE: rdata = st.tare;
      ADDR_TEMP: rdata = st.tempC;
      default: begin
        if (coefHit) begin
          rdata = st.coef[coefIdx];
        end else begin
          hit = 1'b0;
        end
      end
    endcase

    // apb answer one wait state after the access phase opens
    stNext.rsp.pready = access & ~st.rsp.pready;
    if (access && !st.rsp.pready) begin
      stNext.rsp.prdata  = rdata;
      stNext.rsp.pslverr = ~hit;
    end
    wrEn = access & st.rsp.pready & apbReq.pwrite & hit;

    // register writes and commands
    if (wrEn) begin
      case (apbReq.paddr)
        ADDR_CTRL: begin
          stNext.tareEn = apbReq.pwdata[CTRL_TARE_BIT];
          if (cmd == CMD_STOP) begin
            stNext.stopReq = busy;
          end else if (cmd == CMD_TARE) begin
            stNext.tare   = st.lastPres;
            stNext.tareEn = 1'b1;
          end else if (cmd == CMD_READ) begin
            if (!busy && st.holdValid) begin
              stNext.res.valid = 1'b1;
              stNext.res.data  = st.hold;
              stNext.res.kind  = st.holdKind;
              stNext.res.tare  = st.holdTare;
            end
          end else if (cmd != CMD_NONE && !busy) begin
            stNext.mode    = cmd;
            stNext.kind    = rpr_kind_t'(apbReq.pwdata[CTRL_KIND_LSB +: 2]);
            stNext.stopReq = 1'b0;
            stNext.hsCnt   = 5'h0;
            launch         = 1'b1;
          end
        end
        ADDR_PINT: stNext.pInt = apbReq.pwdata[15:0];
        ADDR_TINT: stNext.tInt = apbReq.pwdata[15:0];
        ADDR_TARE: stNext.tare = apbReq.pwdata;
        ADDR_STAT, ADDR_HOLD, ADDR_TEMP: ;
        default: stNext.coef[coefIdx] = apbReq.pwdata;
      endcase
    end
    // measurement sequencer
    case (st.fsm)
      GATE: begin
        stNext.gateCnt = st.gateCnt + 34'h1;
        if (st.armed) begin
          stNext.refCnt = st.refCnt + 34'h1;
          if (rise) begin
            stNext.edges   = st.edges + 34'h1;
            stNext.lastRef = st.refCnt + 34'h1;
          end
        end else if (rise) begin
          stNext.armed  = 1'b1;
          stNext.refCnt = 34'h0;
        end
        if (st.gateCnt + 34'h1 >= gateLen) begin
          // period in us = cycles * ns per cycle / (edges * ns per us)
          stNext.dNum   = {14'h0, stNext.lastRef, 16'h0} * 64'(CLK_PERIOD_NS);
          stNext.dDen   = 48'((stNext.edges == 34'h0) ? 34'h1 : stNext.edges)
                          * 48'(NS_PER_US);
          stNext.dRem   = 48'h0;
          stNext.dCnt   = DIV_STEPS;
          stNext.dRatio = 1'b0;
          stNext.fsm    = DIV;
        end
      end
      DIV: begin
        // restoring divider, one quotient bit per cycle
        if (remTry >= {1'b0, st.dDen}) begin
          stNext.dRem = 48'(remTry - {1'b0, st.dDen});
          stNext.dNum = {st.dNum[62:0], 1'b1};
        end else begin
          stNext.dRem = remTry[47:0];
          stNext.dNum = {st.dNum[62:0], 1'b0};
        end
        stNext.dCnt = st.dCnt - 7'h1;
        stNext.step = 4'h0;
        if (st.dCnt == 7'h1) begin
          if (st.dRatio) begin
            stNext.acc = stNext.dNum[31:0];
            stNext.fsm = CALC_F;
          end else if (!st.gSel) begin
            stNext.tPer = stNext.dNum[31:0];
            stNext.u    = stNext.dNum[31:0] - st.coef[CI_U0];
            if (st.kind == KIND_TPER) begin
              stNext.acc = stNext.dNum[31:0];
              stNext.fsm = EMIT;
            end else begin
              stNext.acc = st.coef[CI_Y3];
              stNext.fsm = CALC_T;
            end
          end else begin
            stNext.pPer = stNext.dNum[31:0];
            if (st.kind == KIND_PPER) begin
              stNext.acc = stNext.dNum[31:0];
              stNext.fsm = EMIT;
            end else begin
              stNext.acc = st.coef[CI_C3];
              stNext.fsm = CALC_P;
            end
          end
        end
      end
      CALC_T: begin
        // horner form of the cubic, no constant term
        stNext.step = st.step + 4'h1;
        case (st.step)
          4'h0: stNext.acc = fxMul(st.acc, st.u) + st.coef[CI_Y2];
          4'h1: stNext.acc = fxMul(st.acc, st.u) + st.coef[CI_Y1];
          default: begin
            stNext.tempC  = fxMul(st.acc, st.u);
            stNext.tempOk = 1'b1;
            if (st.kind == KIND_TEMP) begin
              stNext.acc = fxMul(st.acc, st.u);
              stNext.fsm = EMIT;
            end else begin
              startGate = 1'b1;
              gateSel   = 1'b1;
            end
          end
        endcase
      end
      CALC_P: begin
        // C, D and tau0 polynomials in the offset temperature period
        stNext.step = st.step + 4'h1;
        case (st.step)
          4'h0: stNext.acc = fxMul(st.acc, st.u) + st.coef[CI_C2];
          4'h1: begin
            stNext.cC  = fxMul(st.acc, st.u) + st.coef[CI_C1];
            stNext.acc = st.coef[CI_D2];
          end
          4'h2: begin
            stNext.dD  = fxMul(st.acc, st.u) + st.coef[CI_D1];
            stNext.acc = st.coef[CI_T5];
          end
          4'h3: stNext.acc = fxMul(st.acc, st.u) + st.coef[CI_T4];
          4'h4: stNext.acc = fxMul(st.acc, st.u) + st.coef[CI_T3];
          4'h5: stNext.acc = fxMul(st.acc, st.u) + st.coef[CI_T2];
          default: begin
            // ratio tau0 / tau through the shared divider
            stNext.dNum   = {16'h0, fxMul(st.acc, st.u) + st.coef[CI_T1], 16'h0};
            stNext.dDen   = {16'h0, st.pPer};
            stNext.dRem   = 48'h0;
            stNext.dCnt   = DIV_STEPS;
            stNext.dRatio = 1'b1;
            stNext.fsm    = DIV;
          end
        endcase
      end
      CALC_F: begin
        stNext.step = st.step + 4'h1;
        case (st.step)
          4'h0: stNext.xv  = FX_ONE - fxMul(st.acc, st.acc);
          4'h1: stNext.acc = FX_ONE - fxMul(st.dD, st.xv);
          4'h2: stNext.acc = fxMul(st.acc, st.xv);
          4'h3: stNext.acc = fxMul(st.acc, st.cC) + st.coef[CI_ZERO];
          4'h4: stNext.acc = fxMul(st.acc, st.coef[CI_UNIT]);
          4'h5: begin
            stNext.acc      = fxMul(st.acc, st.coef[CI_SPAN]);
            stNext.lastPres = fxMul(st.acc, st.coef[CI_SPAN]);
          end
          default: begin
            if (st.tareEn) begin
              stNext.acc = st.acc - st.tare;
            end
            stNext.fsm = EMIT;
          end
        endcase
      end
      EMIT: begin
        if (st.mode == CMD_TRIG) begin
          stNext.hold      = st.acc;
          stNext.holdValid = 1'b1;
          stNext.holdKind  = st.kind;
          stNext.holdTare  = st.tareEn && (st.kind == KIND_PRES);
        end else begin
          stNext.res.valid = 1'b1;
          stNext.res.data  = st.acc;
          stNext.res.kind  = st.kind;
          stNext.res.tare  = st.tareEn && (st.kind == KIND_PRES);
        end
        if ((st.mode == CMD_CONT || st.mode == CMD_FAST) && !st.stopReq) begin
          launch = 1'b1;
        end else begin
          stNext.fsm     = IDLE;
          stNext.stopReq = 1'b0;
        end
      end
      default: ;
    endcase
    // new measurement: fast mode skips temperature while the held value is fresh
    if (launch) begin
      startGate = 1'b1;
      gateSel   = (stNext.kind == KIND_PPER)
                  || (stNext.kind == KIND_PRES && stNext.mode == CMD_FAST
                      && st.tempOk && stNext.hsCnt != 5'h0);
      if (stNext.mode == CMD_FAST) begin
        stNext.hsCnt = (stNext.hsCnt == HS_LAST) ? 5'h0 : stNext.hsCnt + 5'h1;
      end
    end
    if (startGate) begin
      stNext.gSel    = gateSel;
      stNext.armed   = 1'b0;
      stNext.gateCnt = 34'h0;
      stNext.refCnt  = 34'h0;
      stNext.lastRef = 34'h0;
      stNext.edges   = 34'h0;
      stNext.fsm     = GATE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register, coefficient table loads factory values at reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st      <= '0;
      st.pInt <= PINT_RST;
      st.tInt <= TINT_RST;
      st.coef <= COEF_RST;
    end else begin
      st <= stNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence sApbOpen;
    apbReq.psel && apbReq.penable && !st.rsp.pready;
  endsequence
  sequence sTempDone;
    st.fsm == CALC_T && st.step == 4'h2;
  endsequence
  sequence sGateEnd;
    st.fsm == GATE ##1 st.fsm == DIV;
  endsequence
  chk_apb_wait: assert property (sApbOpen |=> st.rsp.pready)
    else $error("apb answer missing");
  chk_gate_bound: assert property (st.fsm == GATE |-> st.gateCnt < gateLen)
    else $error("gate ran past its length");
  chk_pint_load: assert property (
    wrEn && apbReq.paddr == ADDR_PINT |=> st.pInt == $past(apbReq.pwdata[15:0]))
    else $error("pressure gate time not stored");
  chk_temp_first: assert property (
    sTempDone ##0 st.kind == KIND_PRES |=> st.fsm == GATE && st.gSel)
    else $error("pressure gate did not follow temperature");
  chk_temp_only: assert property (
    st.kind == KIND_TEMP |-> !(st.fsm == GATE && st.gSel))
    else $error("temperature request gated pressure");
  chk_period_raw: assert property (
    st.fsm == DIV && st.dCnt == 7'h1 && !st.dRatio && st.kind == KIND_TPER
    |=> st.fsm == EMIT && st.acc == st.tPer)
    else $error("raw period not passed out");
  chk_single_once: assert property (
    st.fsm == EMIT && st.mode == CMD_SINGLE |=> st.fsm == IDLE && st.res.valid)
    else $error("single mode did not stop after one result");
  chk_cont_repeat: assert property (
    st.fsm == EMIT && st.mode == CMD_CONT && !st.stopReq |=> st.fsm == GATE && st.res.valid)
    else $error("continuous mode did not restart");
  chk_fast_reuse: assert property (
    st.fsm == EMIT && st.mode == CMD_FAST && !st.stopReq && st.kind == KIND_PRES
    && st.tempOk && st.hsCnt != 5'h0 |=> st.fsm == GATE && st.gSel)
    else $error("fast mode remeasured temperature");
  chk_hold_capture: assert property (
    st.fsm == EMIT && st.mode == CMD_TRIG
    |=> st.holdValid && st.hold == $past(st.acc) && !st.res.valid)
    else $error("hold mode result not held");
  chk_tare_sub: assert property (
    st.fsm == CALC_F && st.step == 4'h6 && st.tareEn
    |=> st.acc == $past(st.acc) - $past(st.tare))
    else $error("tare not subtracted");
  chk_span_reset: assert property (
    $fell(srst) |-> st.coef[CI_SPAN] == FX_ONE && st.coef[CI_ZERO] == 32'h0)
    else $error("span or zero adder reset wrong");
  chk_div_length: assert property (sGateEnd |-> (st.fsm == DIV) [*8])
    else $error("period division cut short");
endmodule

// ### verif/resonant_pressure_period_readout_tb.sv
// self-checking bench for the period readout: apb master tasks and scenarios
// assumes the transducer model sets a 1 us pressure and 2 us temperature period
module resonant_pressure_period_readout_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rpr_pkg::*;
  localparam int CPM = 125;
  logic         core_clk = 1'b0;
  logic         srst     = 1'b1;
  rpr_apb_req_t apbReq   = '0;
  rpr_apb_rsp_t apbRsp;
  logic         presSig;
  logic         tempSig;
  rpr_result_t  result;
  rpr_result_t  lastRes;
  int           resCnt   = 0;
  int           cyc      = 0;
  int           resCyc   = 0;
  int           errTotal = 0;
  int           checkCount = 0;
  logic [31:0]  rd;
  logic         er;

  rpr_readout #(.CYC_PER_MS(CPM)) dut (
    .core_clk(core_clk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
    .presSig(presSig), .tempSig(tempSig), .result(result));
  rpr_xducer_model xdcr (.core_clk(core_clk), .presSig(presSig), .tempSig(tempSig));

  always #4 core_clk = ~core_clk;

  // cycle count and capture of each result pulse
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (result.valid === 1'b1) begin
      resCnt <= resCnt + 1;
      lastRes <= result;
      resCyc <= cyc;
    end
  end
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer: setup, access, hold until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (apbRsp.pready === 1'b1) begin
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq <= '0;
        return;
      end
    end
    errTotal++;
    stop_test();
  endtask

  task automatic cf(logic w, int i, logic [31:0] d);
    apb(w, ADDR_COEF + 8'(4 * i), d);
  endtask

  task automatic ctl(rpr_cmd_t c, rpr_kind_t k, logic t);
    apb(1'b1, ADDR_CTRL, {23'h0, t, 2'h0, k, 1'b0, c});
  endtask

  task automatic wait_res(int n, int lim);
    for (int i = 0; i < lim; i++) begin
      if (resCnt >= n) return;
      @(posedge core_clk);
    end
    errTotal++;
    stop_test();
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 1000; i++) begin
      apb(1'b0, ADDR_STAT, 32'h0);
      if (rd[0] === 1'b0) return;
    end
    errTotal++;
    stop_test();
  endtask

  // single start, wait for its word, then for idle
  task automatic run(rpr_kind_t k, logic t, output int lat);
    int c0;
    int n;
    n = resCnt;
    ctl(CMD_SINGLE, k, t);
    c0 = cyc;
    wait_res(n + 1, 3000);
    lat = resCyc - c0;
    wait_idle();
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, ADDR_PINT, 32'h0);
    chk(rd, 32'h3e8);
    apb(1'b0, ADDR_TINT, 32'h0);
    chk(rd, 32'h3e8);
    cf(1'b0, CI_SPAN, 32'h0);
    chk(rd, FX_ONE);
    cf(1'b0, CI_ZERO, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(er), 32'h1);
    cf(1'b1, NCOEF, 32'h5);
    chk(32'(er), 32'h1);
  endtask

  // gates and coefficients: u0 0.5, y 2/0.5/0.25, c1 3, d1 0.5, tau0 0.5
  task automatic t_setup();
    apb(1'b1, ADDR_PINT, 32'h4);
    apb(1'b1, ADDR_TINT, 32'h6);
    cf(1'b1, CI_U0, 32'h0000_8000);
    cf(1'b1, CI_Y1, 32'h0002_0000);
    cf(1'b1, CI_Y2, 32'h0000_8000);
    cf(1'b1, CI_Y3, 32'h0000_4000);
    cf(1'b1, CI_C1, 32'h0003_0000);
    cf(1'b1, CI_D1, 32'h0000_8000);
    cf(1'b1, CI_T1, 32'h0000_8000);
    cf(1'b0, CI_Y1, 32'h0);
    chk(rd, 32'h0002_0000);
  endtask

  task automatic t_meas();
    int d;
    int n;
    run(KIND_TPER, 1'b0, d);
    chk(lastRes.data, 32'h0002_0000);
    chk(32'(lastRes.kind), 32'(KIND_TPER));
    run(KIND_PPER, 1'b0, d);
    chk(lastRes.data, 32'h0001_0000);
    run(KIND_TEMP, 1'b0, d);
    chk(lastRes.data, 32'h0004_f800);
    apb(1'b0, ADDR_TEMP, 32'h0);
    chk(rd, 32'h0004_f800);
    n = resCnt;
    run(KIND_PRES, 1'b0, d);
    chk(lastRes.data, 32'h0001_6800);
    chk(32'(d >= 10 * CPM), 32'h1);
    chk(32'(lastRes.tare), 32'h0);
    repeat (600) @(posedge core_clk);
    chk(32'(resCnt), 32'(n + 1));
    cf(1'b1, CI_ZERO, 32'h0001_0000);
    cf(1'b1, CI_SPAN, 32'h0002_0000);
    run(KIND_PRES, 1'b0, d);
    chk(lastRes.data, 32'h0004_d000);
    apb(1'b1, ADDR_TARE, 32'h0001_0000);
    run(KIND_PRES, 1'b1, d);
    chk(lastRes.data, 32'h0003_d000);
    chk(32'(lastRes.tare), 32'h1);
    // tare to the current pressure: last pressure before tare subtraction is 4.8125
    ctl(CMD_TARE, KIND_PRES, 1'b0);
    apb(1'b0, ADDR_TARE, 32'h0);
    chk(rd, 32'h0004_d000);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(32'(rd[4]), 32'h1);
    run(KIND_PRES, 1'b1, d);
    chk(lastRes.data, 32'h0);
    chk(32'(lastRes.tare), 32'h1);
  endtask

  task automatic t_modes();
    int n;
    int m;
    int d2;
    int d4;
    n = resCnt;
    ctl(CMD_TRIG, KIND_PPER, 1'b0);
    wait_idle();
    chk(32'(resCnt), 32'(n));
    apb(1'b0, ADDR_HOLD, 32'h0);
    chk(rd, 32'h0001_0000);
    ctl(CMD_READ, KIND_PPER, 1'b0);
    wait_res(n + 1, 5);
    chk(lastRes.data, 32'h0001_0000);
    n = resCnt;
    ctl(CMD_CONT, KIND_PPER, 1'b0);
    wait_res(n + 3, 6000);
    ctl(CMD_STOP, KIND_PPER, 1'b0);
    wait_idle();
    m = resCnt;
    repeat (800) @(posedge core_clk);
    chk(32'(resCnt), 32'(m));
    chk(lastRes.data, 32'h0001_0000);
    // fast mode: later pressure runs reuse temperature, so they are shorter than a temp gate
    n = resCnt;
    ctl(CMD_FAST, KIND_PRES, 1'b0);
    wait_res(n + 2, 6000);
    m = resCyc;
    wait_res(n + 3, 3000);
    chk(32'(resCyc - m < 6 * CPM), 32'h1);
    chk(lastRes.data, 32'h0004_d000);
    ctl(CMD_STOP, KIND_PRES, 1'b0);
    wait_idle();
    apb(1'b1, ADDR_PINT, 32'h2);
    run(KIND_PPER, 1'b0, d2);
    apb(1'b1, ADDR_PINT, 32'h4);
    run(KIND_PPER, 1'b0, d4);
    chk(32'(d4 - d2), 32'(2 * CPM));
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_setup();
    t_meas();
    t_modes();
    stop_test();
  end
endmodule

// ### verif/rpr_xducer_model.sv
// transducer stand-in: two free-running square waves, pressure and temperature
// assumes it is clocked by core_clk, so every edge is synchronous to the block
module rpr_xducer_model #(
  parameter int PRES_CYC = 125,
  parameter int TEMP_CYC = 250
) (
  input  wire logic core_clk,
  output logic      presSig = 1'b0,
  output logic      tempSig = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  int pCnt = 0;
  int tCnt = 0;
  ////////////////////////////////////////
  // a resonator never stops: one rising edge per period, gate or no gate
  always @(posedge core_clk) begin
    pCnt <= (pCnt == PRES_CYC - 1) ? 0 : pCnt + 1;
    tCnt <= (tCnt == TEMP_CYC - 1) ? 0 : tCnt + 1;
    presSig <= (pCnt < PRES_CYC / 2);
    tempSig <= (tCnt < TEMP_CYC / 2);
  end
endmodule
